// *** rtl/sccct_timer.sv ***
`timescale 1ns/100ps
`include "sccct_regs.svh"

module sccct_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic channel_input_pin,
    input wire logic trigger_in,
    output logic compare_output,
    output logic compare_output_en,
    output logic channel_event_flag,
    output logic overcapture_flag
);
    // ====================================================
    // state; every register of the block sits in this one struct, so
    // reset and the clocked update stay in a single place
    sccct_pkg::sccct_state_t s_r, s_nxt;

    // ====================================================
    // filter table: {sampling-clock ticks per sample minus one, run length}
    // kept as one function so the whole decode reads as a single list
    function automatic logic [8:0] filt_cfg(input logic [3:0] code);
        unique case (code)
            4'h0: filt_cfg = {5'h00, 4'h1};
            4'h1: filt_cfg = {5'h00, 4'h2};
            4'h2: filt_cfg = {5'h00, 4'h4};
            4'h3: filt_cfg = {5'h00, 4'h8};
            4'h4: filt_cfg = {5'h01, 4'h6};
            4'h5: filt_cfg = {5'h01, 4'h8};
            4'h6: filt_cfg = {5'h03, 4'h6};
            4'h7: filt_cfg = {5'h03, 4'h8};
            4'h8: filt_cfg = {5'h07, 4'h6};
            4'h9: filt_cfg = {5'h07, 4'h8};
            4'hA: filt_cfg = {5'h0F, 4'h5};
            4'hB: filt_cfg = {5'h0F, 4'h6};
            4'hC: filt_cfg = {5'h0F, 4'h8};
            4'hD: filt_cfg = {5'h1F, 4'h5};
            4'hE: filt_cfg = {5'h1F, 4'h6};
            4'hF: filt_cfg = {5'h1F, 4'h8};
        endcase
    endfunction

    // ====================================================
    // bus decode
    // only the low address byte is decoded, so the map aliases above it
    logic setup_ph, wr_acc, rd_acc, addr_ok;
    logic [7:0] a8;
    assign a8 = 8'(paddr);
    assign setup_ph = psel && !penable;
    assign addr_ok = (a8 == `SCCCT_OFF_CTRL) || (a8 == `SCCCT_OFF_STAT)
        || (a8 == `SCCCT_OFF_EGEN) || (a8 == `SCCCT_OFF_MODE)
        || (a8 == `SCCCT_OFF_CCER) || (a8 == `SCCCT_OFF_CNT)
        || (a8 == `SCCCT_OFF_PSC) || (a8 == `SCCCT_OFF_ARR)
        || (a8 == `SCCCT_OFF_RCR) || (a8 == `SCCCT_OFF_CCR);
    // zero wait states; read data is latched during setup
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_acc = psel && penable && pwrite && addr_ok;
    assign rd_acc = psel && penable && !pwrite && addr_ok;

    // outputs straight from flops, no logic after the state register
    assign prdata = s_r.prdata;
    assign compare_output = s_r.oc;
    assign compare_output_en = s_r.oc_en;
    assign channel_event_flag = s_r.ccif;
    assign overcapture_flag = s_r.ccof;

    // ====================================================
    // next-state logic
    always_comb begin
        logic [15:0] wd;
        logic [1:0] dir;
        logic ch_en, is_out, is_in, preload, fast;
        logic run, tick, ovf, upd, sw_upd, tr_edge, ccg;
        logic dts_tick, smp_tick, smp;
        logic [1:0] edge_sel;
        logic ic_ev, cap, match;
        logic [8:0] fc;
        logic [2:0] div_top;
        sccct_pkg::sccct_om_t om;
        s_nxt = s_r;
        wd = pwdata[15:0];
        dir = s_r.mode[1:0];
        ch_en = s_r.ccer[`SCCCT_CCER_EN];
        edge_sel = {s_r.ccer[`SCCCT_CCER_AUX], s_r.ccer[`SCCCT_CCER_POL]};
        is_out = (dir == `SCCCT_DIR_OUT);
        is_in = (dir == `SCCCT_DIR_IN);
        preload = s_r.mode[3];
        fast = s_r.mode[2];
        om = sccct_pkg::sccct_om_t'(s_r.mode[6:4]);
        upd = 1'b0;
        tick = 1'b0;
        ovf = 1'b0;
        cap = 1'b0;
        match = 1'b0;
        ic_ev = 1'b0;
        // defaults keep every local driven on every path
        run = 1'b0;
        sw_upd = 1'b0;
        tr_edge = 1'b0;
        ccg = 1'b0;
        dts_tick = 1'b0;
        smp = 1'b0;
        fc = 9'h000;
        div_top = 3'h0;

        // three-stage synchronisers; level accepted when stages two and three agree
        s_nxt.in_s = {s_r.in_s[1:0], channel_input_pin};
        if (s_r.in_s[1] == s_r.in_s[2]) begin
            s_nxt.in_lvl = s_r.in_s[2];
        end
        s_nxt.tr_s = {s_r.tr_s[1:0], trigger_in};
        if (s_r.tr_s[1] == s_r.tr_s[2]) begin
            s_nxt.tr_lvl = s_r.tr_s[2];
        end
        // edge detector resets low like the idle pin, so no false edge
        s_nxt.tr_prev = s_r.tr_lvl;
        tr_edge = s_r.tr_lvl && !s_r.tr_prev;

        // software event generation
        // event bits are strobes; they never stay set in any register
        sw_upd = wr_acc && (a8 == `SCCCT_OFF_EGEN) && wd[`SCCCT_EGEN_UG];
        ccg = wr_acc && (a8 == `SCCCT_OFF_EGEN) && wd[`SCCCT_EGEN_CCG];

        // ====================================================
        // time base; a non-fast trigger restarts the count, so the output
        // only moves once the comparison itself changes
        run = s_r.ctrl[`SCCCT_CTRL_EN] && (s_r.period_value != 16'h0000);
        if (sw_upd || (tr_edge && !fast)) begin
            s_nxt.pre_cnt = 16'h0000;
            s_nxt.cnt = 16'h0000;
            upd = 1'b1;
        end else if (run) begin
            if (s_r.pre_cnt == s_r.psc_act) begin
                s_nxt.pre_cnt = 16'h0000;
                tick = 1'b1;
            end else begin
                s_nxt.pre_cnt = s_r.pre_cnt + 16'h0001;
            end
        end
        if (tick) begin
            if (s_r.cnt >= s_r.period_value) begin
                s_nxt.cnt = 16'h0000;
                ovf = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
        end
        // repetition countdown: update only when it has reached zero
        if (ovf) begin
            if (s_r.overflow_countdown == 8'h00) begin
                upd = 1'b1;
            end else begin
                s_nxt.overflow_countdown = s_r.overflow_countdown - 8'h01;
            end
        end
        // update: shadow copies load together, so a new period starts clean
        if (upd) begin
            s_nxt.overflow_countdown = s_r.overflows_per_update;
            s_nxt.psc_act = s_r.tick_divider;
            if (preload) begin
                s_nxt.ccr_act = s_r.ccr;
            end
            if (ovf && s_r.ctrl[`SCCCT_CTRL_OPM]) begin
                s_nxt.ctrl[`SCCCT_CTRL_EN] = 1'b0;
            end
        end

        // ====================================================
        // compare reference, judged against the active value
        match = tick && (s_r.cnt == s_r.ccr_act);
        unique case (om)
            sccct_pkg::SCCCT_OM_FROZEN: s_nxt.ref_lvl = s_r.ref_lvl;
            sccct_pkg::SCCCT_OM_SET: s_nxt.ref_lvl = s_r.ref_lvl | match;
            sccct_pkg::SCCCT_OM_CLR: s_nxt.ref_lvl = s_r.ref_lvl & !match;
            sccct_pkg::SCCCT_OM_TOG: s_nxt.ref_lvl = s_r.ref_lvl ^ match;
            sccct_pkg::SCCCT_OM_LOW: s_nxt.ref_lvl = 1'b0;
            sccct_pkg::SCCCT_OM_HIGH: s_nxt.ref_lvl = 1'b1;
            sccct_pkg::SCCCT_OM_PWM1: s_nxt.ref_lvl = (s_r.cnt < s_r.ccr_act);
            sccct_pkg::SCCCT_OM_PWM2: s_nxt.ref_lvl = !(s_r.cnt < s_r.ccr_act);
        endcase
        // limitation: fast latency includes the three-flop synchroniser
        // fast path: trigger forces pwm1 high and pwm2 low, in pwm modes only
        if (fast && tr_edge && om[2:1] == 2'h3) begin
            s_nxt.ref_lvl = (om == sccct_pkg::SCCCT_OM_PWM1);
        end
        // pin stage; aux polarity is assumed clear in output mode
        // enable follows the registered config, one clock after a write
        s_nxt.oc_en = ch_en && is_out;
        s_nxt.oc = (ch_en && is_out) ? (s_nxt.ref_lvl ^ s_r.ccer[`SCCCT_CCER_POL])
            : 1'b0;

        // ====================================================
        // input filter on the dead-time sampling clock
        dts_tick = (s_r.dts_cnt == 2'((2'h1 << s_r.ctrl[9:8]) - 2'h1));
        s_nxt.dts_cnt = dts_tick ? 2'h0 : s_r.dts_cnt + 2'h1;
        fc = filt_cfg(s_r.mode[7:4]);
        smp_tick = 1'b0;
        if (dts_tick) begin
            if (s_r.smp_cnt >= fc[8:4]) begin
                s_nxt.smp_cnt = 5'h00;
                smp_tick = 1'b1;
            end else begin
                s_nxt.smp_cnt = s_r.smp_cnt + 5'h01;
            end
        end
        // run length counts differing samples; an equal sample restarts it
        smp = s_r.in_lvl;
        if (smp_tick) begin
            if (smp == s_r.filt) begin
                s_nxt.run_cnt = 4'h0;
            end else if (s_r.run_cnt + 4'h1 >= fc[3:0]) begin
                s_nxt.filt = smp;
                s_nxt.run_cnt = 4'h0;
            end else begin
                s_nxt.run_cnt = s_r.run_cnt + 4'h1;
            end
        end
        s_nxt.filt_prev = s_r.filt;

        // edge select; the reserved pair selects nothing
        unique case (edge_sel)
            `SCCCT_EDGE_RISE: ic_ev = s_r.filt && !s_r.filt_prev;
            `SCCCT_EDGE_FALL: ic_ev = !s_r.filt && s_r.filt_prev;
            `SCCCT_EDGE_BOTH: ic_ev = s_r.filt != s_r.filt_prev;
            default: ic_ev = 1'b0;
        endcase

        // capture divider, held clear while the channel is off
        div_top = 3'((4'h1 << s_r.mode[3:2]) - 4'h1);
        if (!ch_en) begin
            s_nxt.div_cnt = 3'h0;
        end else if (ic_ev && is_in) begin
            if (s_r.div_cnt >= div_top) begin
                s_nxt.div_cnt = 3'h0;
                cap = 1'b1;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 3'h1;
            end
        end
        // a software capture bypasses the divider, as a strobe should
        if (ccg && is_in && ch_en) begin
            cap = 1'b1;
        end

        // ====================================================
        // register writes
        // writes land after the time base but before capture, so software overrides the time base that cycle
        if (wr_acc) begin
            unique case (a8)
                `SCCCT_OFF_CTRL: s_nxt.ctrl = wd & `SCCCT_CTRL_MASK;
                `SCCCT_OFF_MODE: begin
                    s_nxt.mode = wd & `SCCCT_MODE_MASK;
                    if (ch_en) begin
                        s_nxt.mode[1:0] = s_r.mode[1:0];
                    end
                end
                `SCCCT_OFF_CCER: begin
                    s_nxt.ccer = wd & `SCCCT_CCER_MASK;
                    if (s_r.ctrl[13] && is_out) begin
                        s_nxt.ccer[`SCCCT_CCER_POL] = s_r.ccer[`SCCCT_CCER_POL];
                    end
                end
                `SCCCT_OFF_CNT: s_nxt.cnt = wd;
                `SCCCT_OFF_PSC: s_nxt.tick_divider = wd;
                `SCCCT_OFF_ARR: s_nxt.period_value = wd;
                `SCCCT_OFF_RCR: s_nxt.overflows_per_update = wd[7:0];
                `SCCCT_OFF_CCR: begin
                    s_nxt.ccr = wd;
                    if (!preload) begin
                        s_nxt.ccr_act = wd;
                    end
                end
                default: ;
            endcase
        end

        // flags: write 0 clears, a coincident set wins; reading the
        // capture value in input mode also clears the event flag
        if (wr_acc && a8 == `SCCCT_OFF_STAT) begin
            s_nxt.uif = s_r.uif & wd[`SCCCT_STAT_UIF];
            s_nxt.ccif = s_r.ccif & wd[`SCCCT_STAT_CCIF];
            s_nxt.ccof = s_r.ccof & wd[`SCCCT_STAT_CCOF];
        end
        if (rd_acc && a8 == `SCCCT_OFF_CCR && is_in) begin
            s_nxt.ccif = 1'b0;
        end
        if (upd) begin
            s_nxt.uif = 1'b1;
        end
        if ((match || ccg) && is_out) begin
            s_nxt.ccif = 1'b1;
        end
        // capture stores the running count
        if (cap) begin
            s_nxt.ccr = s_r.cnt;
            s_nxt.ccr_act = s_r.cnt;
            s_nxt.ccif = 1'b1;
            if (s_r.ccif) begin
                s_nxt.ccof = 1'b1;
            end
        end

        // ====================================================
        // read mux, latched in setup so prdata is a flop
        // trade-off: the value seen is the one standing at the setup edge
        if (setup_ph && !pwrite) begin
            unique case (a8)
                `SCCCT_OFF_CTRL: s_nxt.prdata = {16'h0000, s_r.ctrl};
                `SCCCT_OFF_STAT: s_nxt.prdata = {22'h000000, s_r.ccof, 7'h00,
                    s_r.ccif, s_r.uif};
                `SCCCT_OFF_MODE: s_nxt.prdata = {16'h0000, s_r.mode};
                `SCCCT_OFF_CCER: s_nxt.prdata = {16'h0000, s_r.ccer};
                `SCCCT_OFF_CNT: s_nxt.prdata = {16'h0000, s_r.cnt};
                `SCCCT_OFF_PSC: s_nxt.prdata = {16'h0000, s_r.tick_divider};
                `SCCCT_OFF_ARR: s_nxt.prdata = {16'h0000, s_r.period_value};
                `SCCCT_OFF_RCR: s_nxt.prdata = {24'h000000, s_r.overflows_per_update};
                `SCCCT_OFF_CCR: s_nxt.prdata = {16'h0000, s_r.ccr};
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end
    end

    // ====================================================
    // state register, synchronous reset
    // the whole struct clears, so every flop-driven output starts low; pready and pslverr follow the bus
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// *** rtl/sccct_regs.svh ***
`ifndef SCCCT_REGS_SVH
`define SCCCT_REGS_SVH
// ====================================================
// register byte offsets
`define SCCCT_OFF_CTRL 8'h00
`define SCCCT_OFF_STAT 8'h10
`define SCCCT_OFF_EGEN 8'h14
`define SCCCT_OFF_MODE 8'h18
`define SCCCT_OFF_CCER 8'h20
`define SCCCT_OFF_CNT 8'h24
`define SCCCT_OFF_PSC 8'h28
`define SCCCT_OFF_ARR 8'h2C
`define SCCCT_OFF_RCR 8'h30
`define SCCCT_OFF_CCR 8'h34
// ====================================================
// writable masks, reserved bits stay zero
`define SCCCT_CTRL_MASK 16'h3309
`define SCCCT_MODE_MASK 16'h00FF
`define SCCCT_CCER_MASK 16'h000B
`define SCCCT_RCR_MASK 16'h00FF
`define SCCCT_STAT_MASK 16'h0203
// ====================================================
// field positions
`define SCCCT_CTRL_EN 0
`define SCCCT_CTRL_OPM 3
`define SCCCT_STAT_UIF 0
`define SCCCT_STAT_CCIF 1
`define SCCCT_STAT_CCOF 9
`define SCCCT_EGEN_UG 0
`define SCCCT_EGEN_CCG 1
`define SCCCT_CCER_EN 0
`define SCCCT_CCER_POL 1
`define SCCCT_CCER_AUX 3
// ====================================================
// direction and polarity codes
`define SCCCT_DIR_OUT 2'h0
`define SCCCT_DIR_IN 2'h1
`define SCCCT_EDGE_RISE 2'h0
`define SCCCT_EDGE_FALL 2'h1
`define SCCCT_EDGE_BOTH 2'h3
`endif

// *** rtl/sccct_pkg.sv ***
package sccct_pkg;
    // output reference modes
    typedef enum logic [2:0] {
        SCCCT_OM_FROZEN, SCCCT_OM_SET, SCCCT_OM_CLR, SCCCT_OM_TOG,
        SCCCT_OM_LOW, SCCCT_OM_HIGH, SCCCT_OM_PWM1, SCCCT_OM_PWM2
    } sccct_om_t;

    // whole state of the timer
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] mode;
        logic [15:0] ccer;
        logic [15:0] cnt;
        logic [15:0] tick_divider;
        logic [15:0] psc_act;
        logic [15:0] pre_cnt;
        logic [15:0] period_value;
        logic [7:0] overflows_per_update;
        logic [7:0] overflow_countdown;
        logic [15:0] ccr;
        logic [15:0] ccr_act;
        logic uif;
        logic ccif;
        logic ccof;
        logic ref_lvl;
        logic oc;
        logic oc_en;
        logic [2:0] in_s;
        logic in_lvl;
        logic [2:0] tr_s;
        logic tr_lvl;
        logic tr_prev;
        logic [1:0] dts_cnt;
        logic [4:0] smp_cnt;
        logic [3:0] run_cnt;
        logic filt;
        logic filt_prev;
        logic [2:0] div_cnt;
        logic [31:0] prdata;
    } sccct_state_t;
endpackage

// *** tb/sccct_pin_model.sv ***
`timescale 1ns/100ps
// ====================================================
// pin side: capture input and trigger, both idle low
module sccct_pin_model (
    input wire logic clk,
    output logic channel_input_pin,
    output logic trigger_in
);
    // idle low at time zero, as with a pull-down on the pins
    initial begin
        channel_input_pin = 1'b0;
        trigger_in = 1'b0;
    end
    // hold the capture pin at one level for n clocks
    task automatic pin(input logic v, input int n);
        @(posedge clk);
        channel_input_pin <= v;
        repeat (n - 1) @(posedge clk);
    endtask
    // one rising trigger edge, held long enough for the synchroniser
    task automatic trig();
        @(posedge clk);
        trigger_in <= 1'b1;
        repeat (6) @(posedge clk);
        trigger_in <= 1'b0;
    endtask
endmodule

// *** tb/sccct_timer_checker.sv ***
`timescale 1ns/100ps
`include "sccct_regs.svh"
// ====================================================
// port checks for the timer
module sccct_timer_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic compare_output,
    input wire logic compare_output_en,
    input wire logic channel_event_flag,
    input wire logic overcapture_flag
);
    logic [7:0] a;
    logic mapped;
    logic acc;
    logic cfg_wr;
    logic stat_wr;
    // decode on the low byte only, as the design does
    assign a = paddr[7:0];
    assign mapped = a inside {`SCCCT_OFF_CTRL, `SCCCT_OFF_STAT, `SCCCT_OFF_EGEN,
        `SCCCT_OFF_MODE, `SCCCT_OFF_CCER, `SCCCT_OFF_CNT, `SCCCT_OFF_PSC,
        `SCCCT_OFF_ARR, `SCCCT_OFF_RCR, `SCCCT_OFF_CCR};
    assign acc = psel && penable;
    assign cfg_wr = acc && pwrite && (a == `SCCCT_OFF_CCER || a == `SCCCT_OFF_MODE);
    assign stat_wr = acc && pwrite && a == `SCCCT_OFF_STAT;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // setup then access, qualified at setup
    sequence s_xfer(logic m);
        psel && !penable && m ##1 acc;
    endsequence
    AST_ERR_UNMAPPED: assert property (s_xfer(!mapped) |-> pslverr)
        else $error("unmapped access without error");
    AST_OK_MAPPED: assert property (s_xfer(mapped) |-> !pslverr)
        else $error("mapped access flagged as error");
    AST_RD_ZERO: assert property (s_xfer(!mapped && !pwrite) |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    AST_OUT_OFF: assert property (!compare_output_en |-> !compare_output)
        else $error("output driven while disabled");
    // enable only moves after a config write, registered so one or two edges
    AST_OE_CAUSE: assert property ($changed(compare_output_en) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("output enable changed without config write");
    AST_OVC_PAST: assert property ($rose(overcapture_flag) |-> $past(channel_event_flag))
        else $error("overcapture without pending event");
    AST_OVC_EVT: assert property ($rose(overcapture_flag) |-> channel_event_flag)
        else $error("overcapture without event flag");
    AST_EVT_FALL: assert property ($fell(channel_event_flag) |-> $past(stat_wr) ||
        $past(acc && !pwrite && a == `SCCCT_OFF_CCR))
        else $error("event flag dropped by itself");
    AST_OVC_FALL: assert property ($fell(overcapture_flag) |-> $past(stat_wr))
        else $error("overcapture flag dropped by itself");
endmodule
bind sccct_timer sccct_timer_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .compare_output(compare_output), .compare_output_en(compare_output_en),
    .channel_event_flag(channel_event_flag), .overcapture_flag(overcapture_flag));

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`include "sccct_regs.svh"
// ====================================================
// bench top
module tb_top;
    logic clk;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin;
    logic trg;
    logic oc;
    logic oc_en;
    logic evt;
    logic ovc;
    int miscompares;
    int num_checks;
    int hi;
    int rise;
    logic [31:0] q;
    logic e;
    logic [7:0] ra [9] = '{`SCCCT_OFF_CTRL, `SCCCT_OFF_STAT, `SCCCT_OFF_MODE, `SCCCT_OFF_CCER,
        `SCCCT_OFF_CNT, `SCCCT_OFF_PSC, `SCCCT_OFF_ARR, `SCCCT_OFF_RCR, `SCCCT_OFF_CCR};
    // polarity setting and expected capture {on rise, on fall}
    logic [31:0] pc [5] = '{32'h0, 32'h1, 32'h3, 32'hB, 32'h9};
    logic [1:0] pe [5] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0};
    sccct_timer dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .channel_input_pin(pin), .trigger_in(trg), .compare_output(oc),
        .compare_output_en(oc_en), .channel_event_flag(evt), .overcapture_flag(ovc));
    sccct_pin_model m (.clk(clk), .channel_input_pin(pin), .trigger_in(trg));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ====================================================
    // bus and compare helpers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // count high samples and rising edges of the output, after a short settle
    task automatic meas(input int n);
        logic prev;
        repeat (4) @(posedge clk);
        hi = 0;
        rise = 0;
        prev = oc;
        repeat (n) begin
            @(posedge clk);
            hi += int'(oc === 1'b1);
            rise += int'(oc === 1'b1 && prev === 1'b0);
            prev = oc;
        end
    endtask
    task automatic pulse();
        m.pin(1'b1, 12);
        m.pin(1'b0, 12);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog, far beyond the expected run of well under two thousand clocks
    initial begin
        #1000000;
        miscompares++;
        give_verdict();
    end
    // ====================================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        foreach (ra[i]) rc(ra[i], 32'h0);
        wr(`SCCCT_OFF_CCER, 32'hFFFFFFFF);
        rc(`SCCCT_OFF_CCER, 32'h0000000B);
        wr(`SCCCT_OFF_CCER, 32'h0);
        wr(`SCCCT_OFF_RCR, 32'hFFFFFFFF);
        rc(`SCCCT_OFF_RCR, 32'h000000FF);
        apb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        chk(32'(e), 32'h1);
        wr(`SCCCT_OFF_CCER, 32'h1);
        wr(`SCCCT_OFF_MODE, 32'h1);
        rc(`SCCCT_OFF_MODE, 32'h0);
        wr(`SCCCT_OFF_CCER, 32'h0);
        wr(`SCCCT_OFF_CTRL, 32'h2000);
        wr(`SCCCT_OFF_CCER, 32'h2);
        rc(`SCCCT_OFF_CCER, 32'h0);
        // pwm1 with preload: 3 of every 10 counts high
        wr(`SCCCT_OFF_ARR, 32'h9);
        wr(`SCCCT_OFF_CCR, 32'h3);
        wr(`SCCCT_OFF_MODE, 32'h68);
        wr(`SCCCT_OFF_CCER, 32'h1);
        wr(`SCCCT_OFF_CTRL, 32'h1);
        for (int p = 0; p < 2; p++) begin
            wr(`SCCCT_OFF_PSC, 32'(p));
            wr(`SCCCT_OFF_EGEN, 32'h1);
            meas(40);
            chk(hi, 32'h0C);
            chk(rise, 32'(4 >> p));
        end
        wr(`SCCCT_OFF_CCER, 32'h3);
        meas(40);
        chk(hi, 32'h1C);
        wr(`SCCCT_OFF_CCER, 32'h1);
        wr(`SCCCT_OFF_CCR, 32'h7);
        meas(40);
        chk(hi, 32'h0C);
        rc(`SCCCT_OFF_CCR, 32'h7);
        wr(`SCCCT_OFF_MODE, 32'h60);
        wr(`SCCCT_OFF_CCR, 32'h7);
        meas(40);
        chk(hi, 32'h1C);
        wr(`SCCCT_OFF_CCER, 32'h0);
        repeat (3) @(posedge clk);
        chk({oc_en, oc}, 2'h0);
        // trigger against a stopped counter that never matches
        wr(`SCCCT_OFF_CTRL, 32'h0);
        wr(`SCCCT_OFF_CCR, 32'h0);
        wr(`SCCCT_OFF_CCER, 32'h1);
        fork m.trig(); meas(40); join
        chk(hi, 32'h0);
        wr(`SCCCT_OFF_MODE, 32'h64);
        fork m.trig(); meas(40); join
        chk(hi != 0, 1'b1);
        // repetition of one: update only every second overflow
        wr(`SCCCT_OFF_RCR, 32'h1);
        wr(`SCCCT_OFF_CTRL, 32'h1);
        wr(`SCCCT_OFF_EGEN, 32'h1);
        wr(`SCCCT_OFF_STAT, 32'h0);
        // first overflow after 20 clocks must not update, the second must
        repeat (20) @(posedge clk);
        apb(1'b0, `SCCCT_OFF_STAT, 32'h0);
        chk(q[0], 1'b0);
        repeat (20) @(posedge clk);
        apb(1'b0, `SCCCT_OFF_STAT, 32'h0);
        chk(q[0], 1'b1);
        wr(`SCCCT_OFF_ARR, 32'h0);
        wr(`SCCCT_OFF_CNT, 32'h5);
        repeat (10) @(posedge clk);
        rc(`SCCCT_OFF_CNT, 32'h5);
        // capture with the counter frozen so each stored value is known
        wr(`SCCCT_OFF_CTRL, 32'h0);
        for (int d = 3; d >= 0; d--) begin
            wr(`SCCCT_OFF_CCER, 32'h0);
            wr(`SCCCT_OFF_MODE, 32'(1 + 4 * d));
            wr(`SCCCT_OFF_STAT, 32'h0);
            wr(`SCCCT_OFF_CCER, 32'h1);
            for (int k = 1; k <= (1 << d); k++) begin
                wr(`SCCCT_OFF_CNT, 32'(k));
                pulse();
                chk(evt, k == (1 << d));
            end
            rc(`SCCCT_OFF_CCR, 32'(1 << d));
        end
        pulse();
        pulse();
        chk({ovc, evt}, 2'h3);
        for (int i = 0; i < 5; i++) begin
            wr(`SCCCT_OFF_CCER, pc[i]);
            repeat (8) @(posedge clk);
            wr(`SCCCT_OFF_STAT, 32'h0);
            m.pin(1'b1, 12);
            chk(evt, pe[i][1]);
            wr(`SCCCT_OFF_STAT, 32'h0);
            m.pin(1'b0, 12);
            chk(evt, pe[i][0]);
        end
        // filter of eight equal samples rejects a short glitch
        wr(`SCCCT_OFF_CCER, 32'h0);
        wr(`SCCCT_OFF_MODE, 32'h31);
        wr(`SCCCT_OFF_CCER, 32'h1);
        wr(`SCCCT_OFF_STAT, 32'h0);
        m.pin(1'b1, 4);
        m.pin(1'b0, 12);
        chk(evt, 1'b0);
        pulse();
        chk(evt, 1'b1);
        // half-rate sampling: the same twelve-clock pulse is now too short
        wr(`SCCCT_OFF_CTRL, 32'h100);
        wr(`SCCCT_OFF_STAT, 32'h0);
        pulse();
        chk(evt, 1'b0);
        m.pin(1'b1, 20);
        m.pin(1'b0, 12);
        chk(evt, 1'b1);
        wr(`SCCCT_OFF_CCER, 32'h0);
        wr(`SCCCT_OFF_MODE, 32'h2);
        wr(`SCCCT_OFF_CCER, 32'h1);
        wr(`SCCCT_OFF_STAT, 32'h0);
        pulse();
        chk({oc_en, evt}, 2'h0);
        give_verdict();
    end
endmodule
